// >>> dv/fpp_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_stage_model (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic gate_i,
   input wire logic short_i,
   output logic [9:0] sense_level_o
);
   // Switch current climbs one code per on-cycle and is gone once the switch opens.
   // A shorted sense resistor reads zero however long the switch conducts.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sense_level_o <= 10'h000;
      end else if (!gate_i || short_i) begin
         sense_level_o <= 10'h000;
      end else if (sense_level_o != 10'h3ff) begin
         sense_level_o <= sense_level_o + 10'h001;
      end
   end
endmodule
`default_nettype wire

// >>> dv/test_flyback_pwm_protection_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_flyback_pwm_protection_ctrl;
   logic clk_sys_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, d;
   logic supply_on_i, supply_low_i, supply_floor_i, fb_light_i, fb_zero_i, fb_recover_i;
   logic gate_o, hv_startup_o, supply_discharge_o;
   logic [9:0] feedback_input_i, sense_level_i, line_sense_pin_i, peak;
   logic [4:0] flt;
   logic bus_err;
   int seed = 21526;
   int bad_count, n_checks, cyc_n, w, t0, t1, t2, k, rf;
   int cyc[5] = '{20, 100, 50, 100, 50};
   fpp_ctrl #(.SS_CYC(640), .OTP1_CYC(100), .OTP2_CYC(50), .OLP_CYC(100),
      .OVP_CYC(20)) u_fpp_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .supply_on_i(supply_on_i), .supply_low_i(supply_low_i),
      .supply_floor_i(supply_floor_i), .supply_ovp_i(flt[0]), .fb_open_i(flt[3]),
      .fb_light_i(fb_light_i), .fb_zero_i(fb_zero_i), .fb_recover_i(fb_recover_i),
      .thermal_first_i(flt[1]), .thermal_second_i(flt[2]),
      .feedback_input_i(feedback_input_i), .sense_level_i(sense_level_i),
      .line_sense_pin_i(line_sense_pin_i), .gate_o(gate_o), .hv_startup_o(hv_startup_o),
      .supply_discharge_o(supply_discharge_o));
   fpp_stage_model u_fpp_stage_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .gate_i(gate_o), .short_i(flt[4]), .sense_level_o(sense_level_i));
   always #5 clk_sys_i = ~clk_sys_i;
   // The line wanders below its peak, so each window must really find the maximum.
   always @(posedge clk_sys_i) begin
      cyc_n <= cyc_n + 1;
      line_sense_pin_i <= ($random(seed) & 3) ? peak - 10'($random(seed) & 15) : peak;
   end
   function automatic logic [9:0] lim_f(input int pk, input logic half);
      int l;
      l = 46 - ((pk - 100) >>> 3);
      if (l < 39) l = 39;
      if (half) l = l / 2;
      return 10'(l);
   endfunction
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task fail_to;
      bad_count++;
      $display("[ERR] t=%0t wait timed out got %h exp %h", $time, 1'b0, 1'b1);
      end_sim;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys_i); n++; end while (pready_o !== 1'b1 && n < 100);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 100) fail_to;
   endtask
   task rd_reg(input logic [11:0] a);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      `CHK(e, 1'b0)
   endtask
   task wr_reg(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, v, x, e);
   endtask
   task wait_state(input logic [2:0] s);
      int n;
      n = 0;
      do begin rd_reg(12'h004); n++; end while (d[2:0] !== s && n < 8000);
      if (n >= 8000) fail_to;
      `CHK(d[2:0], s)
   endtask
   // Rise time in cycles and on-time, sampled on the edges.
   task pulse(output int wd, output int tr);
      int n;
      n = 0;
      while (gate_o !== 1'b0 && n < 9000) begin @(posedge clk_sys_i); n++; end
      while (gate_o !== 1'b1 && n < 9000) begin @(posedge clk_sys_i); n++; end
      if (n >= 9000) fail_to;
      tr = cyc_n;
      wd = 0;
      while (gate_o === 1'b1 && wd < 2000) begin @(posedge clk_sys_i); wd++; end
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   initial begin
      clk_sys_i = 0; reset_i = 1; psel_i = 0; penable_i = 0; pwrite_i = 0;
      paddr_i = 0; pwdata_i = 0; supply_on_i = 0; supply_low_i = 1; supply_floor_i = 1;
      fb_light_i = 0; fb_zero_i = 0; fb_recover_i = 1; flt = 0; cyc_n = 0;
      feedback_input_i = 10'd200; peak = 10'(100 + ($random(seed) & 63));
      bad_count = 0; n_checks = 0;
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      `CHK({hv_startup_o, supply_discharge_o, gate_o}, 3'b100)
      rd_reg(12'h000);
      `CHK(d, 32'h1)
      rd_reg(12'h008);
      `CHK(d, 32'h0)
      apb(1'b0, 12'h010, 32'h0, d, bus_err);
      `CHK({bus_err, d}, {1'b1, 32'h0})
      supply_low_i <= 0; supply_floor_i <= 0; supply_on_i <= 1;
      wait_state(3'h1);
      `CHK({hv_startup_o, supply_discharge_o}, 2'b00)
      done("startup");
      k = 0;
      do begin rd_reg(12'h004); k++; end while (d[4] !== 1'b1 && k < 9000);
      `CHK(d[4], 1'b1)
      rd_reg(12'h00c);
      `CHK(d[9:0], peak)
      `CHK(d[25:16], lim_f(peak, 1'b0))
      done("line");
      // Blanked pulse: the reference is below the blanking length.
      feedback_input_i <= 10'd150;
      pulse(w, t0);
      pulse(w, t0);
      `CHK(w inside {[29:31]}, 1'b1)
      feedback_input_i <= 10'(180 + ($random(seed) & 31));
      pulse(w, t0);
      pulse(w, t0);
      rf = (feedback_input_i - 60) >> 2;
      `CHK(w inside {[rf:rf + 3]}, 1'b1)
      pulse(w, t1);
      `CHK(t1 - t0, 1536)
      fb_light_i <= 1'b1;
      pulse(w, t0);
      pulse(w, t1);
      pulse(w, t2);
      `CHK((t2 - t1) - (t1 - t0), 1)
      fb_light_i <= 1'b0;
      done("pulses");
      fb_zero_i <= 1'b1;
      fb_recover_i <= 1'b0;
      repeat (40) @(posedge clk_sys_i);
      k = 0;
      repeat (3200) begin @(posedge clk_sys_i); k += (gate_o !== 1'b0); end
      `CHK(k, 0)
      rd_reg(12'h004);
      `CHK(d[3], 1'b1)
      fb_zero_i <= 1'b0;
      fb_recover_i <= 1'b1;
      pulse(w, t0);
      wr_reg(12'h000, 32'h5);
      repeat (9000) @(posedge clk_sys_i);
      rd_reg(12'h00c);
      `CHK(d[25:16], lim_f(peak, 1'b1))
      wr_reg(12'h000, 32'h1);
      done("zero and halve");
      for (int i = 0; i < 5; i++) begin
         if (i < 4) begin
            flt[i] <= 1'b1;
            repeat (cyc[i] - 2) @(posedge clk_sys_i);
            flt[i] <= 1'b0;
            wait_state(3'h1);
         end
         flt[i] <= 1'b1;
         wait_state(3'h2);
         rd_reg(12'h008);
         `CHK(d[4:0], 5'(1 << i))
         `CHK(gate_o, 1'b0)
         flt[i] <= 1'b0; supply_on_i <= 0; supply_low_i <= 1;
         wait_state(3'h3);
         `CHK(supply_discharge_o, 1'b1)
         supply_floor_i <= 1'b1;
         wait_state(3'h0);
         `CHK(hv_startup_o, 1'b1)
         wr_reg(12'h008, 32'h1f);
         rd_reg(12'h008);
         `CHK(d, 32'h0)
         supply_low_i <= 0; supply_floor_i <= 0; supply_on_i <= 1;
         wait_state(3'h1);
      end
      done("faults");
      wr_reg(12'h000, 32'h3);
      flt[2] <= 1'b1;
      wait_state(3'h4);
      flt[2] <= 1'b0; supply_on_i <= 0; supply_low_i <= 1; supply_floor_i <= 1;
      repeat (50) @(posedge clk_sys_i);
      wait_state(3'h4);
      `CHK({hv_startup_o, gate_o}, 2'b00)
      done("latch");
      end_sim;
   end
endmodule
`default_nettype wire

// >>> hdl/fpp_consts.svh
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH
`define FPP_CLK_MHZ 100
`define FPP_SS_MS 8
`define FPP_SS_CYC (`FPP_SS_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_OTP1_MS 16
`define FPP_OTP1_CYC (`FPP_OTP1_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_OTP2_US 185
`define FPP_OTP2_CYC (`FPP_OTP2_US * `FPP_CLK_MHZ)
`define FPP_OLP_MS 56
`define FPP_OLP_CYC (`FPP_OLP_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_SENSE_SHORT_GUARD_US 120
`define FPP_SENSE_SHORT_GUARD_CYC (`FPP_SENSE_SHORT_GUARD_US * `FPP_CLK_MHZ)
`define FPP_OVP_US 100
`define FPP_OVP_CYC (`FPP_OVP_US * `FPP_CLK_MHZ)
`define FPP_LEB_NS 280
`define FPP_LEB_CYC ((`FPP_LEB_NS * `FPP_CLK_MHZ + 999) / 1000)
`define FPP_FMIN_KHZ 22
`define FPP_PER_MAX_CYC ((`FPP_CLK_MHZ * 1000) / `FPP_FMIN_KHZ)
`define FPP_PER_NORM_CYC 13'h0600
`define FPP_DUTY_MAX_CYC 13'h0540
`define FPP_PER_STEP 13'h0001
`define FPP_RAMP_SHIFT 7
`define FPP_SS_STEPS 64
`define FPP_FB_OFS 10'h03c
`define FPP_LIM_LOW 10'h02e
`define FPP_LIM_HIGH 10'h027
`define FPP_LINE_REF 10'h064
`define FPP_LIM_SHIFT 3
`define FPP_BROWN_IN 10'h05a
`define FPP_BROWN_OUT 10'h051
`define FPP_SENSE_SHORT_GUARD_LVL 10'h005
`define FPP_SAMP_CYC 16'h03e8
`define FPP_SAMP_LIGHT_SHIFT 2
`define FPP_UPD_SAMPLES 4'h8
`define FPP_REG_CTRL 12'h000
`define FPP_REG_STATUS 12'h004
`define FPP_REG_FAULT 12'h008
`define FPP_REG_LINE 12'h00c
`define FPP_CTRL_RUN_BIT 0
`define FPP_CTRL_LATCH_BIT 1
`define FPP_CTRL_HALVE_BIT 2
`define FPP_CTRL_RST 3'h1
`define FPP_FLT_OVP 0
`define FPP_FLT_OTP1 1
`define FPP_FLT_OTP2 2
`define FPP_FLT_OLP 3
`define FPP_FLT_SENSE_SHORT_GUARD 4
`endif

// >>> hdl/fpp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpp_consts.svh"
module fpp_ctrl #(
   parameter int unsigned SS_CYC = `FPP_SS_CYC,
   parameter int unsigned OTP1_CYC = `FPP_OTP1_CYC,
   parameter int unsigned OTP2_CYC = `FPP_OTP2_CYC,
   parameter int unsigned OLP_CYC = `FPP_OLP_CYC,
   parameter int unsigned SENSE_SHORT_GUARD_CYC = `FPP_SENSE_SHORT_GUARD_CYC,
   parameter int unsigned OVP_CYC = `FPP_OVP_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic supply_on_i,
   input wire logic supply_low_i,
   input wire logic supply_floor_i,
   input wire logic supply_ovp_i,
   input wire logic fb_open_i,
   input wire logic fb_light_i,
   input wire logic fb_zero_i,
   input wire logic fb_recover_i,
   input wire logic thermal_first_i,
   input wire logic thermal_second_i,
   input wire logic [9:0] feedback_input_i,
   input wire logic [9:0] sense_level_i,
   input wire logic [9:0] line_sense_pin_i,
   output logic gate_o,
   output logic hv_startup_o,
   output logic supply_discharge_o
);
   localparam int unsigned SS_STEP = SS_CYC / `FPP_SS_STEPS;
   localparam int unsigned SSW = $clog2(SS_STEP + 1);

   function automatic fpp_pkg::fpp_code_t sub_floor(input fpp_pkg::fpp_code_t a,
                                                    input fpp_pkg::fpp_code_t b);
      sub_floor = (a > b) ? a - b : 10'h000;
   endfunction

   function automatic fpp_pkg::fpp_code_t min_code(input fpp_pkg::fpp_code_t a,
                                                   input fpp_pkg::fpp_code_t b);
      min_code = (a < b) ? a : b;
   endfunction

   fpp_pkg::fpp_state_e state_q;
   fpp_pkg::fpp_state_e state_d;
   logic [2:0] ctrl_q;
   logic [4:0] fault_q;
   logic [4:0] fault_hit;
   logic [31:0] rdata_d;
   logic rd_ok;
   logic wr_en;
   logic rd_en;
   logic [12:0] per_len_q;
   logic [12:0] per_cnt_q;
   logic gate_q;
   logic [5:0] blank_cnt_q;
   fpp_pkg::fpp_code_t ramp_q;
   fpp_pkg::fpp_code_t limit_q;
   fpp_pkg::fpp_code_t lim_base;
   fpp_pkg::fpp_code_t drop;
   fpp_pkg::fpp_code_t vref;
   fpp_pkg::fpp_code_t held;
   logic [10:0] sense_sum;
   logic [5:0] ss_level_q;
   logic [SSW-1:0] ss_cnt_q;
   logic brown_ok_q;
   logic zero_q;
   logic upd;
   logic run_ok;
   logic trip;
   logic sense_low;
   logic flt_latch;
   logic flt_restart;
   logic running;

   assign running = (state_q == fpp_pkg::st_run);

   fpp_line_peak u_line (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .line_i(line_sense_pin_i),
      .light_i(fb_light_i),
      .held_o(held),
      .update_o(upd)
   );

   // Each protection is a comparator bit held true for its own cycle count.
   fpp_debounce #(.CYC(OVP_CYC)) u_ovp (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(supply_ovp_i && running),
      .hold_i(1'b0), .hit_o(fault_hit[`FPP_FLT_OVP])
   );
   fpp_debounce #(.CYC(OTP1_CYC)) u_otp1 (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(thermal_first_i && running),
      .hold_i(1'b0), .hit_o(fault_hit[`FPP_FLT_OTP1])
   );
   fpp_debounce #(.CYC(OTP2_CYC)) u_otp2 (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(thermal_second_i && running),
      .hold_i(1'b0), .hit_o(fault_hit[`FPP_FLT_OTP2])
   );
   fpp_debounce #(.CYC(OLP_CYC)) u_olp (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(fb_open_i && running),
      .hold_i(1'b0), .hit_o(fault_hit[`FPP_FLT_OLP])
   );
   // Sense is naturally low while the switch is off, so off-time only pauses the count.
   assign sense_low = (sense_level_i < `FPP_SENSE_SHORT_GUARD_LVL);
   fpp_debounce #(.CYC(SENSE_SHORT_GUARD_CYC)) u_sense_short_guard (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(running && !(gate_q && !sense_low)),
      .hold_i(!gate_q), .hit_o(fault_hit[`FPP_FLT_SENSE_SHORT_GUARD])
   );

   assign flt_latch = ctrl_q[`FPP_CTRL_LATCH_BIT] &&
                      (fault_hit[`FPP_FLT_OVP] || fault_hit[`FPP_FLT_OTP1] ||
                       fault_hit[`FPP_FLT_OTP2]);
   assign flt_restart = |fault_hit;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fpp_pkg::st_charge: begin
            if (supply_on_i) begin
               state_d = fpp_pkg::st_run;
            end
         end
         fpp_pkg::st_run: begin
            if (flt_latch) begin
               state_d = fpp_pkg::st_latch;
            end else if (flt_restart) begin
               state_d = fpp_pkg::st_stop;
            end else if (supply_low_i) begin
               state_d = fpp_pkg::st_charge;
            end
         end
         fpp_pkg::st_stop: begin
            if (supply_low_i) begin
               state_d = fpp_pkg::st_drain;
            end
         end
         fpp_pkg::st_drain: begin
            if (supply_floor_i) begin
               state_d = fpp_pkg::st_charge;
            end
         end
         fpp_pkg::st_latch: begin
            state_d = fpp_pkg::st_latch;
         end
         default: begin
            state_d = fpp_pkg::st_charge;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= fpp_pkg::st_charge;
      end else begin
         state_q <= state_d;
      end
   end

   assign hv_startup_o = (state_q == fpp_pkg::st_charge);
   assign supply_discharge_o = (state_q == fpp_pkg::st_drain);

   // Line judgement acts only on the update pulse, every eighth window, but then uses the peak of the latest window alone.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         brown_ok_q <= 1'b0;
         limit_q <= `FPP_LIM_LOW;
      end else if (upd) begin
         if (held >= `FPP_BROWN_IN) begin
            brown_ok_q <= 1'b1;
         end else if (held < `FPP_BROWN_OUT) begin
            brown_ok_q <= 1'b0;
         end
         limit_q <= ctrl_q[`FPP_CTRL_HALVE_BIT] ? (lim_base >> 1) : lim_base;
      end
   end

   assign drop = sub_floor(held, `FPP_LINE_REF) >> `FPP_LIM_SHIFT;
   assign lim_base = (drop >= `FPP_LIM_LOW - `FPP_LIM_HIGH) ? `FPP_LIM_HIGH :
                     `FPP_LIM_LOW - drop;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         zero_q <= 1'b0;
      end else if (fb_zero_i) begin
         zero_q <= 1'b1;
      end else if (fb_recover_i) begin
         zero_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ss_level_q <= 6'h00;
         ss_cnt_q <= '0;
      end else if (!running) begin
         ss_level_q <= 6'h00;
         ss_cnt_q <= '0;
      end else if (ss_level_q != 6'h3f) begin
         if (ss_cnt_q == SSW'(SS_STEP - 1)) begin
            ss_cnt_q <= '0;
            ss_level_q <= ss_level_q + 6'h01;
         end else begin
            ss_cnt_q <= ss_cnt_q + SSW'(1);
         end
      end
   end

   assign vref = min_code(sub_floor(feedback_input_i, `FPP_FB_OFS) >> 2,
                          min_code(limit_q, {4'h0, ss_level_q}));
   assign sense_sum = {1'b0, sense_level_i} + {1'b0, ramp_q};
   assign trip = (sense_sum >= {1'b0, vref});
   // The next state is used so the gate drops on the same edge at which run is left.
   assign run_ok = (state_d == fpp_pkg::st_run) && ctrl_q[`FPP_CTRL_RUN_BIT] && brown_ok_q &&
                   !zero_q;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         per_cnt_q <= 13'h0000;
         per_len_q <= `FPP_PER_NORM_CYC;
      end else if (per_cnt_q >= per_len_q - 13'h0001) begin
         per_cnt_q <= 13'h0000;
         if (fb_light_i && per_len_q < 13'(`FPP_PER_MAX_CYC)) begin
            per_len_q <= per_len_q + `FPP_PER_STEP;
         end else if (!fb_light_i && per_len_q > `FPP_PER_NORM_CYC) begin
            per_len_q <= per_len_q - `FPP_PER_STEP;
         end
      end else begin
         per_cnt_q <= per_cnt_q + 13'h0001;
      end
   end

   // Termination is registered, so the pulse ends one clock after the trip is seen.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         gate_q <= 1'b0;
         blank_cnt_q <= 6'h00;
         ramp_q <= 10'h000;
      end else if (per_cnt_q == 13'h0000) begin
         gate_q <= run_ok;
         blank_cnt_q <= 6'(`FPP_LEB_CYC);
         ramp_q <= 10'h000;
      end else begin
         ramp_q <= {4'h0, per_cnt_q[12:`FPP_RAMP_SHIFT]};
         if (blank_cnt_q != 6'h00) begin
            blank_cnt_q <= blank_cnt_q - 6'h01;
         end
         if (!run_ok || per_cnt_q >= `FPP_DUTY_MAX_CYC) begin
            gate_q <= 1'b0;
         end else if (blank_cnt_q == 6'h00 && trip) begin
            gate_q <= 1'b0;
         end
      end
   end

   assign gate_o = gate_q;

   assign pready_o = 1'b1;
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && !penable_i && !pwrite_i;
   assign rd_ok = (paddr_i == `FPP_REG_CTRL) || (paddr_i == `FPP_REG_STATUS) ||
                  (paddr_i == `FPP_REG_FAULT) || (paddr_i == `FPP_REG_LINE);
   assign pslverr_o = psel_i && penable_i && !rd_ok;

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (paddr_i)
         `FPP_REG_CTRL: rdata_d = {29'h0, ctrl_q};
         `FPP_REG_STATUS: rdata_d = {27'h0, brown_ok_q, zero_q, state_q};
         `FPP_REG_FAULT: rdata_d = {27'h0, fault_q};
         `FPP_REG_LINE: rdata_d = {6'h0, limit_q, 6'h0, held};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_o <= rdata_d;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= `FPP_CTRL_RST;
      end else if (wr_en && paddr_i == `FPP_REG_CTRL) begin
         ctrl_q <= pwdata_i[2:0];
      end
   end

   // A protection that trips in the same cycle as a clear stays recorded.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         fault_q <= 5'h00;
      end else if (wr_en && paddr_i == `FPP_REG_FAULT) begin
         fault_q <= (fault_q & ~pwdata_i[4:0]) | fault_hit;
      end else begin
         fault_q <= fault_q | fault_hit;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   a_gate_needs_run: assert property (gate_q |-> running)
      else $error("Gate high outside run state.");
   a_hv_off_run: assert property (running |-> !hv_startup_o)
      else $error("Startup current drawn while running.");
   a_supply_lockout_exit: assert property (running && supply_low_i |=> !running)
      else $error("Run state kept below turn-off level.");
   a_trip_ends: assert property (gate_q && per_cnt_q != 13'h0000 && blank_cnt_q == 6'h00
      && trip |=> !gate_q)
      else $error("Pulse not ended on current trip.");
   a_blank_hold: assert property ($fell(gate_q) && $past(blank_cnt_q) != 6'h00 |->
      !$past(run_ok) || $past(per_cnt_q) == 13'h0000)
      else $error("Pulse ended inside blanking.");
   a_ramp_restart: assert property ($rose(gate_q) |-> ramp_q == 10'h000 ##1
      ramp_q == 10'h000)
      else $error("Ramp not restarted with cycle.");
   a_ss_restart: assert property ($rose(running) |-> ss_level_q == 6'h00)
      else $error("Soft-start not restarted.");
   a_brown_in: assert property (upd && held >= `FPP_BROWN_IN |=> brown_ok_q)
      else $error("Brown-in not declared.");
   a_brown_gate: assert property (!brown_ok_q |=> !gate_q)
      else $error("Gate high in brownout.");
   a_ovp_stop: assert property (running && fault_hit[`FPP_FLT_OVP] |=> !running ##1
      !gate_q)
      else $error("Over-voltage did not stop switching.");
   a_drain_floor: assert property (supply_discharge_o && supply_floor_i |=>
      hv_startup_o)
      else $error("No restart at discharge floor.");

   c_pulse: cover property ($rose(gate_q) ##[1:300] $fell(gate_q));
   c_brown_in: cover property ($rose(brown_ok_q));
   c_olp_stop: cover property (running && fault_hit[`FPP_FLT_OLP] ##1 state_q == fpp_pkg::st_stop);
   c_latch: cover property (state_q == fpp_pkg::st_latch);
endmodule
`default_nettype wire

// >>> hdl/fpp_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_debounce #(
   parameter int unsigned CYC = 16
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic level_i,
   input wire logic hold_i,
   output logic hit_o
);
   localparam int unsigned W = $clog2(CYC + 1);
   logic [W-1:0] cnt_q;

   // Any drop of the level restarts the count, so only an unbroken condition trips.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= '0;
      end else if (!level_i) begin
         cnt_q <= '0;
      end else if (!hold_i && cnt_q != W'(CYC)) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   assign hit_o = (cnt_q == W'(CYC));
endmodule
`default_nettype wire

// >>> hdl/fpp_line_peak.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpp_consts.svh"
module fpp_line_peak (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [9:0] line_i,
   input wire logic light_i,
   output logic [9:0] held_o,
   output logic update_o
);
   logic [15:0] samp_cnt_q;
   logic [15:0] win_len;
   logic [9:0] peak_q;
   logic [9:0] peak_now;
   logic [3:0] upd_cnt_q;
   logic win_end;

   assign win_len = light_i ? (`FPP_SAMP_CYC << `FPP_SAMP_LIGHT_SHIFT) : `FPP_SAMP_CYC;
   assign win_end = (samp_cnt_q >= win_len - 16'h0001);
   assign peak_now = (line_i > peak_q) ? line_i : peak_q;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         samp_cnt_q <= 16'h0000;
      end else if (win_end) begin
         samp_cnt_q <= 16'h0000;
      end else begin
         samp_cnt_q <= samp_cnt_q + 16'h0001;
      end
   end

   // The stored value is refreshed every window, even when it falls.
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         peak_q <= 10'h000;
         held_o <= 10'h000;
      end else if (win_end) begin
         peak_q <= 10'h000;
         held_o <= peak_now;
      end else begin
         peak_q <= peak_now;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         upd_cnt_q <= 4'h0;
         update_o <= 1'b0;
      end else begin
         update_o <= 1'b0;
         if (win_end) begin
            if (upd_cnt_q == `FPP_UPD_SAMPLES - 4'h1) begin
               upd_cnt_q <= 4'h0;
               update_o <= 1'b1;
            end else begin
               upd_cnt_q <= upd_cnt_q + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/fpp_pkg.sv
package fpp_pkg;
   typedef enum logic [2:0] {st_charge, st_run, st_stop, st_drain, st_latch} fpp_state_e;
   typedef logic [9:0] fpp_code_t;
endpackage
